/* src/pc_addr_defs.svh */
// Constants for the program counter, stack and data address generator.
// Assumes a byte-addressed Avalon-MM slave window with 32-bit data.
`ifndef PC_ADDR_DEFS_SVH
`define PC_ADDR_DEFS_SVH

// ************************************************************
// Register byte offsets on the register bus
// ************************************************************
`define OFS_PC_LOW 6'h00
`define OFS_PC_LATCH 6'h04
`define OFS_ARITH_STATUS 6'h08
`define OFS_PTR_A 6'h0C
`define OFS_PTR_B 6'h10
`define OFS_TBL_PTR_LOW 6'h14
`define OFS_TBL_PTR_HIGH 6'h18
`define OFS_TBL_LATCH_LOW 6'h1C
`define OFS_TBL_LATCH_HIGH 6'h20
`define OFS_BANK_SEL 6'h24
`define OFS_STACK_STATUS 6'h28

// ************************************************************
// Field positions and encodings
// ************************************************************
`define STEP_A_LSB 0
`define STEP_B_LSB 2
`define STEP_DEC 2'h0
`define STEP_INC 2'h1
`define STACK_ROOM_BIT 0

// ************************************************************
// Data address map
// ************************************************************
`define WINDOW_A_ADDR 8'h00
`define WINDOW_B_ADDR 8'h08
`define PERIPH_BANKED_LO 8'h10
`define PERIPH_BANKED_HI 8'h17
`define GPR_BANKED_LO 8'h20

// ************************************************************
// Reset values
// ************************************************************
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_STEP 4'hF
`define RST_BUS_WORD 32'h0000_0000

`endif

/* src/pc_addr_gen.sv */
// Program counter, return stack, indirect pointers, bank selector
// and table pointer/latch of an 8-bit core, with an Avalon-MM slave.
// Assumes core commands and indirect requests are synchronous pulses.
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pc_addr_defs.svh"

module pc_addr_gen #(
	parameter int STACK_DEPTH = 16,
	parameter int PERIPH_BANKS = 8,
	parameter int RAM_BANKS = 4
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [5:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire pc_addr_pkg::core_cmd_t core_cmd_in,
	input wire pc_addr_pkg::ind_req_t ind_req_in,
	output logic [15:0] pc_out,
	output logic [15:0] table_addr_out,
	output logic [15:0] table_latch_out,
	output logic [7:0] bank_selector_out,
	output pc_addr_pkg::data_acc_t data_acc_out
);

	// Refuse parameter values the logic cannot serve
	if (STACK_DEPTH != 16)
	begin : g_bad_depth
		$error("pc_addr_gen: the return stack is sixteen deep");
	end
	if (PERIPH_BANKS < 1 || PERIPH_BANKS > 16 ||
		RAM_BANKS < 1 || RAM_BANKS > 16)
	begin : g_bad_banks
		$error("pc_addr_gen: bank counts must be 1 to 16");
	end

	// ************************************************************
	// Helper functions
	// ************************************************************

	// Next pointer value after an indirect access
	function automatic logic [7:0] step_ptr(input logic [7:0] ptr,
		input logic [1:0] mode);
		logic [7:0] r;
		r = ptr;
		if (mode == `STEP_DEC)
		begin
			r = ptr - 8'h01;
		end
		else if (mode == `STEP_INC)
		begin
			r = ptr + 8'h01;
		end
		return r;
	endfunction : step_ptr

	// True when an address names one of the two windows
	function automatic logic is_window(input logic [7:0] addr);
		return addr == `WINDOW_A_ADDR || addr == `WINDOW_B_ADDR;
	endfunction : is_window

	// True when a bus address equals one offset; byte lane 0 is checked in bus_wr
	function automatic logic hit(input logic [5:0] addr,
		input logic [5:0] ofs);
		return addr == ofs;
	endfunction : hit

	// ************************************************************
	// State
	// ************************************************************
	logic [7:0] pc_high_holding_latch;
	logic [3:0] step_modes;
	logic [7:0] indirect_pointer_a;
	logic [7:0] indirect_pointer_b;
	logic [15:0] table_pointer;
	logic [15:0] table_latch;
	logic [15:0] stack_top;
	logic stack_room_flag;
	logic push;
	logic pop;
	logic bus_wr;
	logic bus_rd;
	logic [7:0] wbyte;
	pc_addr_pkg::core_op_t op;
	logic [15:0] opnd;
	logic [7:0] ind_addr;

	assign op = core_cmd_in.op;
	assign opnd = core_cmd_in.operand;
	assign wbyte = avs_writedata_in[7:0];

	// ************************************************************
	// Avalon-MM slave handshake
	// ************************************************************

	// Write lands on the edge where waitrequest is seen low
	assign bus_wr = avs_write_in && !avs_waitrequest_out &&
		avs_byteenable_in[0];
	// Read data is captured while waitrequest is still high
	assign bus_rd = avs_read_in && avs_waitrequest_out;

	// One wait cycle per request, then a single ready cycle
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			avs_waitrequest_out <= 1'b1;
		end
		else if ((avs_read_in || avs_write_in) && avs_waitrequest_out)
		begin
			avs_waitrequest_out <= 1'b0;
		end
		else
		begin
			avs_waitrequest_out <= 1'b1;
		end
	end

	// Read mux; unmapped offsets and upper bits read zero
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			avs_readdata_out <= `RST_BUS_WORD;
		end
		else if (bus_rd)
		begin
			avs_readdata_out <= `RST_BUS_WORD;
			case (avs_address_in)
				`OFS_PC_LOW: avs_readdata_out[7:0] <= pc_out[7:0];
				`OFS_PC_LATCH: avs_readdata_out[7:0] <= pc_high_holding_latch;
				`OFS_ARITH_STATUS: avs_readdata_out[3:0] <= step_modes;
				`OFS_PTR_A: avs_readdata_out[7:0] <= indirect_pointer_a;
				`OFS_PTR_B: avs_readdata_out[7:0] <= indirect_pointer_b;
				`OFS_TBL_PTR_LOW: avs_readdata_out[7:0] <= table_pointer[7:0];
				`OFS_TBL_PTR_HIGH: avs_readdata_out[7:0] <= table_pointer[15:8];
				`OFS_TBL_LATCH_LOW: avs_readdata_out[7:0] <= table_latch[7:0];
				`OFS_TBL_LATCH_HIGH: avs_readdata_out[7:0] <= table_latch[15:8];
				`OFS_BANK_SEL: avs_readdata_out[7:0] <= bank_selector_out;
				`OFS_STACK_STATUS:
					avs_readdata_out[`STACK_ROOM_BIT] <= stack_room_flag;
				default: avs_readdata_out <= `RST_BUS_WORD;
			endcase
		end
	end

	// ************************************************************
	// Return stack
	// ************************************************************

	// Calls, long calls and interrupt entry push; returns pop
	assign push = op == pc_addr_pkg::OP_CALL13 ||
		op == pc_addr_pkg::OP_LONG_SUBROUTINE_JUMP || op == pc_addr_pkg::OP_IRQ;
	assign pop = op == pc_addr_pkg::OP_RETURN ||
		op == pc_addr_pkg::OP_EXIT_WITH_LITERAL || op == pc_addr_pkg::OP_EXIT_FROM_INTERRUPT;

	return_stack #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(16)
	) u_stack (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.push_in(push),
		.pop_in(pop),
		.push_data_in(pc_out),
		.top_data_out(stack_top),
		.room_out(stack_room_flag)
	);

	// ************************************************************
	// Program counter
	// ************************************************************

	// Core commands outrank a bus write to the PC low byte
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			pc_out <= `RST_WORD;
		end
		else
		begin
			case (op)
				pc_addr_pkg::OP_FETCH:
					pc_out <= pc_out + 16'h0001;
				pc_addr_pkg::OP_JUMP13, pc_addr_pkg::OP_CALL13:
					pc_out[12:0] <= opnd[12:0];
				pc_addr_pkg::OP_LONG_SUBROUTINE_JUMP:
					pc_out <= {pc_high_holding_latch, opnd[7:0]};
				pc_addr_pkg::OP_RETURN, pc_addr_pkg::OP_EXIT_WITH_LITERAL,
				pc_addr_pkg::OP_EXIT_FROM_INTERRUPT:
					pc_out <= stack_top;
				pc_addr_pkg::OP_IRQ:
					pc_out <= opnd;
				pc_addr_pkg::OP_PCL_WRITE, pc_addr_pkg::OP_PCL_RMW:
					pc_out <= {pc_high_holding_latch, opnd[7:0]};
				pc_addr_pkg::OP_NONE:
				begin
					if (bus_wr && hit(avs_address_in, `OFS_PC_LOW))
					begin
						pc_out <= {pc_high_holding_latch, wbyte};
					end
				end
				default: pc_out <= pc_out;
			endcase
		end
	end

	// Holding latch; interrupt entry, pops, long calls and RMW leave it alone
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			pc_high_holding_latch <= `RST_BYTE;
		end
		else if (op == pc_addr_pkg::OP_JUMP13 ||
			op == pc_addr_pkg::OP_CALL13)
		begin
			pc_high_holding_latch <= {pc_out[15:13], opnd[12:8]};
		end
		else if (op == pc_addr_pkg::OP_PCL_READ ||
			(bus_rd && hit(avs_address_in, `OFS_PC_LOW)))
		begin
			pc_high_holding_latch <= pc_out[15:8];
		end
		else if (bus_wr && hit(avs_address_in, `OFS_PC_LATCH))
		begin
			pc_high_holding_latch <= wbyte;
		end
	end

	// ************************************************************
	// Indirect pointers and step controls
	// ************************************************************

	// Step mode bits; written by software only
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			step_modes <= `RST_STEP;
		end
		else if (bus_wr && hit(avs_address_in, `OFS_ARITH_STATUS))
		begin
			step_modes <= wbyte[3:0];
		end
	end

	// Post-access step wins over a bus write in the same cycle.
	// Stepping drives no status flag, so a pointer reaching zero
	// is silent to the arithmetic unit.
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			indirect_pointer_a <= `RST_BYTE;
		end
		else if (ind_req_in.valid && !ind_req_in.sel_b)
		begin
			indirect_pointer_a <= step_ptr(indirect_pointer_a,
				step_modes[`STEP_A_LSB +: 2]);
		end
		else if (bus_wr && hit(avs_address_in, `OFS_PTR_A))
		begin
			indirect_pointer_a <= wbyte;
		end
	end

	// Pointer B follows its own step control
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			indirect_pointer_b <= `RST_BYTE;
		end
		else if (ind_req_in.valid && ind_req_in.sel_b)
		begin
			indirect_pointer_b <= step_ptr(indirect_pointer_b,
				step_modes[`STEP_B_LSB +: 2]);
		end
		else if (bus_wr && hit(avs_address_in, `OFS_PTR_B))
		begin
			indirect_pointer_b <= wbyte;
		end
	end

	// ************************************************************
	// Bank selector
	// ************************************************************

	// Bank loads from the decoder take priority over the bus
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			bank_selector_out <= `RST_BYTE;
		end
		else if (op == pc_addr_pkg::OP_LOAD_PBANK)
		begin
			bank_selector_out[3:0] <= opnd[3:0];
		end
		else if (op == pc_addr_pkg::OP_LOAD_RBANK)
		begin
			bank_selector_out[7:4] <= opnd[7:4];
		end
		else if (bus_wr && hit(avs_address_in, `OFS_BANK_SEL))
		begin
			bank_selector_out <= wbyte;
		end
	end

	// ************************************************************
	// Indirect address resolution
	// ************************************************************

	// Pointer value before its post-access step
	assign ind_addr = ind_req_in.sel_b ? indirect_pointer_b :
		indirect_pointer_a;

	// One cycle after the request the resolved address is presented
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			data_acc_out <= '0;
		end
		else
		begin
			data_acc_out.valid <= ind_req_in.valid;
			data_acc_out.addr <= ind_addr;
			data_acc_out.zero_read <= ind_req_in.valid &&
				!ind_req_in.write && is_window(ind_addr);
			data_acc_out.keep_flags <= ind_req_in.valid &&
				ind_req_in.write && is_window(ind_addr);
			if (ind_addr >= `PERIPH_BANKED_LO &&
				ind_addr <= `PERIPH_BANKED_HI)
			begin
				data_acc_out.bank <= bank_selector_out[3:0];
				data_acc_out.banked <= 1'b1;
				data_acc_out.unimpl <=
					32'(bank_selector_out[3:0]) >= PERIPH_BANKS;
			end
			else if (ind_addr >= `GPR_BANKED_LO)
			begin
				data_acc_out.bank <= bank_selector_out[7:4];
				data_acc_out.banked <= 1'b1;
				data_acc_out.unimpl <=
					32'(bank_selector_out[7:4]) >= RAM_BANKS;
			end
			else
			begin
				data_acc_out.bank <= 4'h0;
				data_acc_out.banked <= 1'b0;
				data_acc_out.unimpl <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Table pointer and table latch
	// ************************************************************

	// Word address into program memory for table transfers
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			table_pointer <= `RST_WORD;
		end
		else if (bus_wr && hit(avs_address_in, `OFS_TBL_PTR_LOW))
		begin
			table_pointer[7:0] <= wbyte;
		end
		else if (bus_wr && hit(avs_address_in, `OFS_TBL_PTR_HIGH))
		begin
			table_pointer[15:8] <= wbyte;
		end
	end

	assign table_addr_out = table_pointer;

	// Holding register for program/data transfers, in two bytes
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			table_latch <= `RST_WORD;
		end
		else if (bus_wr && hit(avs_address_in, `OFS_TBL_LATCH_LOW))
		begin
			table_latch[7:0] <= wbyte;
		end
		else if (bus_wr && hit(avs_address_in, `OFS_TBL_LATCH_HIGH))
		begin
			table_latch[15:8] <= wbyte;
		end
	end

	assign table_latch_out = table_latch;

endmodule : pc_addr_gen
`default_nettype wire

/* src/pc_addr_pkg.sv */
// Types shared by the address generator, its checker and its bench.
// Assumes the instruction decoder drives one command per clock.
package pc_addr_pkg;

	// Program-flow commands from the decoder and interrupt logic
	typedef enum logic [3:0] {
		OP_NONE,
		OP_FETCH,
		OP_JUMP13,
		OP_CALL13,
		OP_LONG_SUBROUTINE_JUMP,
		OP_RETURN,
		OP_EXIT_WITH_LITERAL,
		OP_EXIT_FROM_INTERRUPT,
		OP_IRQ,
		OP_PCL_READ,
		OP_PCL_WRITE,
		OP_PCL_RMW,
		OP_LOAD_PBANK,
		OP_LOAD_RBANK
	} core_op_t;

	typedef struct packed {
		core_op_t op;
		logic [15:0] operand;
	} core_cmd_t;

	// Indirect access request through one of the two windows
	typedef struct packed {
		logic valid;
		logic sel_b;
		logic write;
	} ind_req_t;

	// Resolved data address of an indirect access
	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [3:0] bank;
		logic banked;
		logic unimpl;
		logic zero_read;
		logic keep_flags;
	} data_acc_t;

endpackage : pc_addr_pkg

/* src/return_stack.sv */
// Circular return stack with the stack-room flag.
// Assumes push and pop are never requested in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "pc_addr_defs.svh"

module return_stack #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 16
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic push_in,
	input wire logic pop_in,
	input wire logic [WIDTH-1:0] push_data_in,
	output logic [WIDTH-1:0] top_data_out,
	output logic room_out
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	// ************************************************************
	// Storage and pointer
	// ************************************************************
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] sp;
	logic [PW-1:0] next_sp;
	logic locked;
	logic next_locked;

	// Refuse depths the wrapping pointer cannot serve
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("return_stack: DEPTH must be a power of two");
	end

	// Pointer is hidden from software; it only moves on push or pop
	always_comb
	begin
		next_sp = sp;
		next_locked = locked;
		if (push_in)
		begin
			next_sp = sp + PW'(1);
			if (sp == LAST)
			begin
				next_locked = 1'b1;
			end
		end
		else if (pop_in)
		begin
			next_sp = sp - PW'(1);
		end
	end

	// Pointer starts at zero after reset
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			sp <= '0;
			locked <= 1'b0;
		end
		else
		begin
			sp <= next_sp;
			locked <= next_locked;
		end
	end

	// Room flag: clear at the last slot, held clear once a push wraps
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			room_out <= 1'b1;
		end
		else
		begin
			room_out <= !(next_locked || next_sp == LAST);
		end
	end

	// Wrapping overwrites the oldest entry; no reset on data needed
	always_ff @(posedge clk_in)
	begin
		if (push_in)
		begin
			mem[sp] <= push_data_in;
		end
	end

	// Most recent entry, read for the returning instruction
	assign top_data_out = mem[sp - PW'(1)];

endmodule : return_stack
`default_nettype wire

/* tb/pc_addr_gen_assertions.sv */
// Port-level checks on the address generator.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pc_addr_checker #(
	parameter int STACK_DEPTH = 16,
	parameter int PERIPH_BANKS = 8,
	parameter int RAM_BANKS = 4
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic avs_waitrequest_out,
	input wire pc_addr_pkg::core_cmd_t core_cmd_in,
	input wire pc_addr_pkg::ind_req_t ind_req_in,
	input wire logic [15:0] pc_out,
	input wire logic [7:0] bank_selector_out,
	input wire pc_addr_pkg::data_acc_t data_acc_out
);
	// ********
	// Properties
	// ********
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);

	// Call and return taken on consecutive edges
	sequence s_call_then_return;
		core_cmd_in.op == pc_addr_pkg::OP_CALL13 ##1
			core_cmd_in.op == pc_addr_pkg::OP_RETURN;
	endsequence

	AST_BUS_ONE_WAIT: assert property (
		(avs_read_in || avs_write_in) && avs_waitrequest_out |=>
		!avs_waitrequest_out ##1 avs_waitrequest_out)
		else $error("bus answer not after exactly one wait cycle");
	AST_FETCH_INC: assert property (
		core_cmd_in.op == pc_addr_pkg::OP_FETCH |=>
		pc_out == $past(pc_out) + 16'h0001)
		else $error("fetch did not advance the counter by one");
	AST_JUMP13: assert property (
		core_cmd_in.op == pc_addr_pkg::OP_JUMP13 |=> pc_out ==
		{$past(pc_out[15:13]), $past(core_cmd_in.operand[12:0])})
		else $error("short jump target wrong");
	AST_LONG_SUBROUTINE_JUMP_LOW: assert property (
		core_cmd_in.op == pc_addr_pkg::OP_LONG_SUBROUTINE_JUMP |=>
		pc_out[7:0] == $past(core_cmd_in.operand[7:0]))
		else $error("long call low byte wrong");
	AST_CALL_RETURN: assert property (
		s_call_then_return |=> pc_out == $past(pc_out, 2))
		else $error("return did not restore the calling address");
	AST_IND_PULSE: assert property (
		data_acc_out.valid == $past(ind_req_in.valid))
		else $error("access pulse not one cycle after request");
	AST_NULL_READ: assert property (
		data_acc_out.valid |-> data_acc_out.zero_read ==
		(!$past(ind_req_in.write) &&
		(data_acc_out.addr == 8'h00 || data_acc_out.addr == 8'h08)))
		else $error("null access marking wrong");
	AST_NULL_WRITE: assert property (
		data_acc_out.valid |-> data_acc_out.keep_flags ==
		($past(ind_req_in.write) &&
		(data_acc_out.addr == 8'h00 || data_acc_out.addr == 8'h08)))
		else $error("null write marking wrong");
	AST_RAM_BANK: assert property (
		data_acc_out.valid && data_acc_out.addr >= 8'h20 |->
		data_acc_out.bank == $past(bank_selector_out[7:4]) &&
		data_acc_out.unimpl == ($past(bank_selector_out[7:4]) >= RAM_BANKS))
		else $error("ram bank or unimplemented marking wrong");
endmodule : pc_addr_checker

bind pc_addr_gen pc_addr_checker #(.STACK_DEPTH(STACK_DEPTH),
	.PERIPH_BANKS(PERIPH_BANKS), .RAM_BANKS(RAM_BANKS)) u_checker (
	.clk_in(clk_in), .rstn_in(rstn_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
	.core_cmd_in(core_cmd_in), .ind_req_in(ind_req_in), .pc_out(pc_out),
	.bank_selector_out(bank_selector_out), .data_acc_out(data_acc_out));
`default_nettype wire

/* tb/tb_pc_addr_gen.sv */
// Self-checking bench: register bus, core commands, stack, indirect.
// Assumes the design package, design and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_pc_addr_gen;
	logic clk_in, rstn_in, avs_read_in, avs_write_in, avs_waitrequest_out;
	logic [5:0] avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, rdv;
	logic [3:0] avs_byteenable_in, b;
	pc_addr_pkg::core_cmd_t core_cmd_in;
	pc_addr_pkg::ind_req_t ind_req_in;
	pc_addr_pkg::data_acc_t data_acc_out;
	logic [15:0] pc_out, table_addr_out, table_latch_out, exp_pc;
	logic [7:0] bank_selector_out, v, w, lat;
	logic [7:0] r [3:9];
	logic [12:0] x [1:17];
	int errors = 0;
	int n_compared = 0;
	int i, j;

	pc_addr_gen u_dut (.clk_in, .rstn_in, .avs_address_in, .avs_read_in,
		.avs_write_in, .avs_writedata_in, .avs_byteenable_in,
		.avs_readdata_out, .avs_waitrequest_out, .core_cmd_in, .ind_req_in,
		.pc_out, .table_addr_out, .table_latch_out, .bank_selector_out,
		.data_acc_out);

	// ********
	// Clock, watchdog and shared tasks
	// ********
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// Generous limit; the sequence needs under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk_in);
		errors++;
		complete_run();
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Upper data bits carry junk: only the low byte may count
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [7:0] d, input logic [3:0] be);
		@(posedge clk_in);
		avs_address_in <= a;
		avs_writedata_in <= {~d, ~d, ~d, d};
		avs_byteenable_in <= be;
		avs_write_in <= wr;
		avs_read_in <= ~wr;
		@(posedge clk_in);
		while (avs_waitrequest_out !== 1'b0)
			@(posedge clk_in);
		rdv = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		#1; // Let a landed write settle before callers look
	endtask : bus

	task automatic rd(input string what, input logic [5:0] a,
		input logic [31:0] exp);
		bus(1'b0, a, 8'h00, 4'hF);
		check(what, rdv, exp);
	endtask : rd

	// Hold leaves the command up so the next one follows back to back
	task automatic cmd(input pc_addr_pkg::core_op_t op,
		input logic [15:0] opnd, input logic hold);
		@(posedge clk_in);
		core_cmd_in <= '{op: op, operand: opnd};
		if (!hold)
		begin
			@(posedge clk_in);
			core_cmd_in <= '{op: pc_addr_pkg::OP_NONE, operand: 16'h0000};
			#1;
		end
	endtask : cmd

	task automatic ind(input logic sel_b, input logic wr);
		@(posedge clk_in);
		ind_req_in <= '{valid: 1'b1, sel_b: sel_b, write: wr};
		@(posedge clk_in);
		ind_req_in <= '0;
		#1;
	endtask : ind

	task automatic rst(input int n);
		@(posedge clk_in);
		rstn_in <= 1'b0;
		repeat (n) @(posedge clk_in);
		rstn_in <= 1'b1;
	endtask : rst

	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	// ********
	// Main sequence
	// ********
	initial
	begin
		rstn_in = 1'b0;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_address_in = 6'h00;
		avs_writedata_in = 32'h0;
		avs_byteenable_in = 4'hF;
		core_cmd_in = '0;
		ind_req_in = '0;
		void'($urandom(33));
		rst(20);
		bus(1'b1, 6'h2C, 8'hFF, 4'hF);
		for (i = 0; i < 12; i++)
			rd("reset", 6'(4 * i), (i == 2) ? 32'h0F : 32'(i == 10));
		// Random byte registers; masked write must not land
		for (i = 0; i < 4; i++)
			for (j = 3; j < 10; j++)
			begin
				r[j] = 8'($urandom);
				bus(1'b1, 6'(4 * j), r[j], 4'hF);
				bus(1'b1, 6'(4 * j), ~r[j], 4'hE);
				rd("reg_rw", 6'(4 * j), 32'(r[j]));
			end
		check("tbl_ptr", 32'(table_addr_out), 32'({r[6], r[5]}));
		check("tbl_latch", 32'(table_latch_out), 32'({r[8], r[7]}));
		check("bank", 32'(bank_selector_out), 32'(r[9]));
		// Computed jump, then fetches carrying into the high byte
		v = 8'($urandom);
		bus(1'b1, 6'h04, v, 4'hF);
		bus(1'b1, 6'h00, 8'hFE, 4'hF);
		check("pcl_bus", 32'(pc_out), 32'({v, 8'hFE}));
		for (i = 0; i < 3; i++)
			cmd(pc_addr_pkg::OP_FETCH, 16'h0000, 1'b1);
		cmd(pc_addr_pkg::OP_NONE, 16'h0000, 1'b0);
		exp_pc = {v, 8'hFE} + 16'h0003;
		check("fetch", 32'(pc_out), 32'(exp_pc));
		bus(1'b1, 6'h04, 8'h00, 4'hF);
		cmd(pc_addr_pkg::OP_PCL_READ, 16'h0000, 1'b0);
		rd("pcl_read", 6'h04, 32'(exp_pc[15:8]));
		bus(1'b1, 6'h04, 8'h00, 4'hF);
		rd("pcl_value", 6'h00, 32'(exp_pc[7:0]));
		rd("pcl_bus_read", 6'h04, 32'(exp_pc[15:8]));
		lat = exp_pc[15:8];
		for (i = 0; i < 2; i++)
		begin
			w = 8'($urandom);
			cmd(i ? pc_addr_pkg::OP_PCL_RMW : pc_addr_pkg::OP_PCL_WRITE,
				16'(w), 1'b0);
			exp_pc = {lat, w};
			check("pcl_write", 32'(pc_out), 32'(exp_pc));
		end
		rd("rmw_latch", 6'h04, 32'(lat));
		// Long call, interrupt and short call each with its return
		w = 8'($urandom);
		cmd(pc_addr_pkg::OP_LONG_SUBROUTINE_JUMP, 16'(w), 1'b0);
		check("long_subroutine_jump", 32'(pc_out), 32'({lat, w}));
		cmd(pc_addr_pkg::OP_EXIT_WITH_LITERAL, 16'h0000, 1'b0);
		check("exit_with_literal", 32'(pc_out), 32'(exp_pc));
		rd("long_subroutine_jump_latch", 6'h04, 32'(lat));
		x[1] = 13'($urandom);
		cmd(pc_addr_pkg::OP_JUMP13, 16'(x[1]), 1'b0);
		exp_pc = {exp_pc[15:13], x[1]};
		check("jump13", 32'(pc_out), 32'(exp_pc));
		rd("jump13_latch", 6'h04, 32'({exp_pc[15:13], x[1][12:8]}));
		w = 8'($urandom);
		cmd(pc_addr_pkg::OP_IRQ, {w, 8'h08}, 1'b0);
		check("irq", 32'(pc_out), 32'({w, 8'h08}));
		cmd(pc_addr_pkg::OP_EXIT_FROM_INTERRUPT, 16'h0000, 1'b0);
		check("exit_from_interrupt", 32'(pc_out), 32'(exp_pc));
		x[2] = 13'($urandom);
		cmd(pc_addr_pkg::OP_CALL13, 16'(x[2]), 1'b1);
		cmd(pc_addr_pkg::OP_RETURN, 16'h0000, 1'b0);
		check("call_ret", 32'(pc_out), 32'(exp_pc));
		rd("ret_latch", 6'h04, 32'({exp_pc[15:13], x[2][12:8]}));
		// Seventeen calls: room flag drops at Fh, oldest entry lost
		rst(2);
		for (i = 1; i < 18; i++)
		begin
			x[i] = 13'($urandom);
			cmd(pc_addr_pkg::OP_CALL13, 16'(x[i]), 1'b0);
			if (i == 14 || i == 15)
				rd("room", 6'h28, 32'(i == 14));
		end
		for (i = 16; i > 0; i--)
		begin
			cmd(pc_addr_pkg::OP_RETURN, 16'h0000, 1'b0);
			check("wrap_pop", 32'(pc_out), 32'(x[i]));
		end
		rd("room_locked", 6'h28, 32'h0);
		rd("pop_latch", 6'h04, 32'(x[17][12:8]));
		// Pop before any push, then a push locks the flag
		rst(2);
		cmd(pc_addr_pkg::OP_RETURN, 16'h0000, 1'b0);
		rd("pop_first", 6'h28, 32'h0);
		cmd(pc_addr_pkg::OP_CALL13, 16'h0000, 1'b0);
		rd("pop_push", 6'h28, 32'h0);
		rst(2);
		rd("room_reset", 6'h28, 32'h1);
		// Pointer A increments, pointer B decrements, then both hold
		bus(1'b1, 6'h08, 8'h01, 4'hF);
		v = 8'($urandom_range(8'h20, 8'hFE));
		w = 8'($urandom_range(8'h21, 8'hFF));
		bus(1'b1, 6'h0C, v, 4'hF);
		bus(1'b1, 6'h10, w, 4'hF);
		ind(1'b0, 1'b0);
		check("addr_a", 32'(data_acc_out.addr), 32'(v));
		ind(1'b1, 1'b1);
		check("addr_b", 32'(data_acc_out.addr), 32'(w));
		rd("step_inc", 6'h0C, 32'(v + 8'h01));
		rd("step_dec", 6'h10, 32'(w - 8'h01));
		bus(1'b1, 6'h08, 8'h0E, 4'hF);
		ind(1'b0, 1'b0);
		ind(1'b1, 1'b0);
		rd("hold_a", 6'h0C, 32'(v + 8'h01));
		rd("hold_b", 6'h10, 32'(w - 8'h01));
		// Null accesses: zero pointer and a window address
		bus(1'b1, 6'h0C, 8'h00, 4'hF);
		bus(1'b1, 6'h10, 8'h08, 4'hF);
		ind(1'b0, 1'b1);
		check("null_wr", 32'({data_acc_out.zero_read,
			data_acc_out.keep_flags}), 32'h1);
		ind(1'b1, 1'b0);
		check("null_rd", 32'(data_acc_out.zero_read), 32'h1);
		// Banked peripheral and RAM accesses, first two unimplemented
		for (i = 0; i < 8; i++)
		begin
			v = (i < 2) ? 8'hF9 : 8'($urandom);
			w = (i % 2) ? {3'b001, 5'($urandom)} : {5'h02, 3'($urandom)};
			b = (i % 2) ? v[7:4] : v[3:0];
			bus(1'b1, 6'h24, v, 4'hF);
			bus(1'b1, 6'h0C, w, 4'hF);
			ind(1'b0, 1'b0);
			check("banked", 32'({data_acc_out.banked, data_acc_out.bank,
				data_acc_out.unimpl}), 32'({1'b1, b,
				(i % 2) ? (b >= 4'h4) : (b >= 4'h8)}));
		end
		// Decoder bank loads each touch one nibble only
		v = 8'($urandom);
		cmd(pc_addr_pkg::OP_LOAD_PBANK, {8'h00, v}, 1'b0);
		cmd(pc_addr_pkg::OP_LOAD_RBANK, {8'h00, ~v}, 1'b0);
		w = {~v[7:4], v[3:0]};
		check("bank_load", 32'(bank_selector_out), 32'(w));
		complete_run();
	end
endmodule : tb_pc_addr_gen
`default_nettype wire
